// *** rtl/tdea_consts.vh ***
// constants for the telegraph distortion and error analyzer
`ifndef TDEA_CONSTS_VH
`define TDEA_CONSTS_VH

`define TDEA_CLK_HZ       250000000
`define TDEA_AUTO_CLR_S   5
`define TDEA_DC_PER_BIT   7'h64
`define TDEA_DIST_MAX     7'h32
`define TDEA_ERR_MAX      6'h32
`define TDEA_ALIGN_BITS   4'hB
`define TDEA_STOP_BASE    4'h6
`define TDEA_LVL_8        2'h3
`define TDEA_TBDIV_RST    16'h0081
`define TDEA_CTRL_RST     32'h0000_0000

`define TDEA_A_CTRL       8'h00
`define TDEA_A_CMD        8'h04
`define TDEA_A_STATUS     8'h08
`define TDEA_A_ERRCNT     8'h0C
`define TDEA_A_LATCH      8'h10
`define TDEA_A_TBDIV      8'h14

`define TDEA_F_MODE       0
`define TDEA_F_SYNC       3
`define TDEA_F_LVL        4
`define TDEA_F_TSEL       6
`define TDEA_F_AUTO       10
`define TDEA_F_PAREN      11
`define TDEA_F_IVAL       12
`define TDEA_F_INV        15

`define TDEA_C_DCLR       0
`define TDEA_C_PCLR       1
`define TDEA_C_ALIGN      2
`define TDEA_C_RESTART    3

`define TDEA_M_PEAK       3'h0
`define TDEA_M_BIAS       3'h1
`define TDEA_M_END        3'h2
`define TDEA_M_PARITY     3'h3
`define TDEA_M_ALT        3'h4
`define TDEA_M_PRBS       3'h5

`define TDEA_IV_1E2       20'h00064
`define TDEA_IV_1E3       20'h003E8
`define TDEA_IV_1E4       20'h02710
`define TDEA_IV_1E5       20'h186A0
`define TDEA_IV_1E6       20'hF4240

`define TDEA_PRBS_SEED    11'h7FF
`define TDEA_RESP_OKAY    2'h0
`define TDEA_RESP_SLVERR  2'h2

`endif

// *** rtl/tdea_prbs.v ***
// pseudo-random sequence register, free running or seeded from a bit stream
`timescale 1ns/10ps
`default_nettype none
`include "tdea_consts.vh"

module tdea_prbs (
    input  wire clk_i,
    input  wire nrst_i,
    input  wire step_i,
    input  wire seed_en_i,
    input  wire seed_bit_i,
    input  wire long_i,
    output wire bit_o
);
    reg  [10:0] state;
    // 2047 taps 11/9, 511 taps 9/5
    wire        fb = long_i ? (state[10] ^ state[8]) : (state[8] ^ state[4]);

    assign bit_o = fb;

    // seeding from received data makes the checker self-align
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= `TDEA_PRBS_SEED;
        end else if (step_i) begin
            state <= {state[9:0], seed_en_i ? seed_bit_i : fb};
        end
    end
endmodule
`default_nettype wire

// *** rtl/tdea_top.v ***
// distortion and error analyzer measurement logic with an axi4-lite register slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tdea_consts.vh"

// Summary of operation
// - peak mode holds largest distortion seen since clear, 0 to 50 percent
// - held peak stays until an operator clear or auto clear zeroes it
// - auto clear zeroes the peak and average distortion display every five seconds; the error count is not cleared
// - bias mode averages space-to-mark shift; early lights marking, late spacing
// - end mode averages mark-to-space shift; early lights spacing, late marking
// - end measurement only for start-stop input, never synchronous
// - transition select 1..9 measures one transition per character, start-stop only
// - no level change at selected position means no value for that character
// - parity error on 8-level start-stop sets lamp until parity clear
// - error count steps by one per parity or bit error and is displayed
// - at count 50 overflow lights and further errors are not counted
// - finite interval stops counting and lights count complete after that many bits
// - five seconds after count complete the count clears and restarts
// - alternating mode with synchronous input counts errors against one-zero reversals
// - pseudo-random check uses strap-selected 511 or 2047 sequence; source must match
// - one output pulse per detected bit error for an external counter
// - own pseudo-random sequence is generated and driven out
// - parity mode checks 8-level start-stop parity and counts each error
// - distortion counter steps 50 down to zero and up to 50 per bit
// - each measured transition (per mode and transition select) strobes the counter value into the holding register
// - time base at 200x bit rate, halved, then divided by 100 for bit timing
module tdea_top #(
    parameter integer AUTO_CLR_CYCLES = `TDEA_AUTO_CLR_S * `TDEA_CLK_HZ
) (
    input  wire        clk_i,
    input  wire        nrst_i,
    input  wire [7:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output reg  [1:0]  s_axi_bresp_o,
    output reg         s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [7:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output reg  [31:0] s_axi_rdata_o,
    output reg  [1:0]  s_axi_rresp_o,
    output reg         s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    input  wire        line_i,
    input  wire        prbs_long_strap_i,
    output reg         pattern_o,
    output reg         err_pulse_o,
    output reg         bit_sync_o,
    output wire        marking_o,
    output wire        spacing_o,
    output reg         parity_err_o,
    output wire        overflow_o,
    output reg         count_comp_o
);
    localparam [30:0] AUTO_LAST = AUTO_CLR_CYCLES[30:0] - 31'h1;
    localparam [1:0]  ADJ_NONE  = 2'h0;
    localparam [1:0]  ADJ_HOLD  = 2'h1;
    localparam [1:0]  ADJ_FAST  = 2'h2;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    function [19:0] ival_limit;
        input [2:0] sel;
        begin
            case (sel)
                3'h1:    ival_limit = `TDEA_IV_1E2;
                3'h2:    ival_limit = `TDEA_IV_1E3;
                3'h3:    ival_limit = `TDEA_IV_1E4;
                3'h4:    ival_limit = `TDEA_IV_1E5;
                3'h5:    ival_limit = `TDEA_IV_1E6;
                default: ival_limit = 20'h00000;
            endcase
        end
    endfunction

    // register slave
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg  [31:0] ctrl;
    reg  [15:0] tbdiv;
    wire        do_wr = aw_held && w_held && !s_axi_bvalid_o;
    wire        wr_map = (awaddr_q == `TDEA_A_CTRL) || (awaddr_q == `TDEA_A_CMD)
                      || (awaddr_q == `TDEA_A_TBDIV);
    wire        cmd_wr = do_wr && (awaddr_q == `TDEA_A_CMD) && wstrb_q[0];
    wire        cmd_dclr = cmd_wr && wdata_q[`TDEA_C_DCLR];
    wire        cmd_pclr = cmd_wr && wdata_q[`TDEA_C_PCLR];
    wire        cmd_align = cmd_wr && wdata_q[`TDEA_C_ALIGN];
    wire        cmd_restart = cmd_wr && wdata_q[`TDEA_C_RESTART];
    wire [31:0] tbdiv_m = merge({16'h0000, tbdiv}, wdata_q, wstrb_q);

    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;

    wire [2:0]  mode = ctrl[`TDEA_F_MODE +: 3];
    wire        sync = ctrl[`TDEA_F_SYNC];
    wire [1:0]  lvl  = ctrl[`TDEA_F_LVL +: 2];
    wire [3:0]  tsel = ctrl[`TDEA_F_TSEL +: 4];
    wire        auto_en = ctrl[`TDEA_F_AUTO];
    wire        par_en = ctrl[`TDEA_F_PAREN];
    wire [2:0]  ival = ctrl[`TDEA_F_IVAL +: 3];
    wire        inv = ctrl[`TDEA_F_INV];

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            awaddr_q       <= 8'h00;
            wdata_q        <= 32'h0000_0000;
            wstrb_q        <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `TDEA_RESP_OKAY;
            ctrl           <= `TDEA_CTRL_RST;
            tbdiv          <= `TDEA_TBDIV_RST;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held  <= 1'b1;
                awaddr_q <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held  <= 1'b1;
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
            if (do_wr) begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_map ? `TDEA_RESP_OKAY : `TDEA_RESP_SLVERR;
                if (awaddr_q == `TDEA_A_CTRL) begin
                    ctrl <= merge(ctrl, wdata_q, wstrb_q);
                end
                if (awaddr_q == `TDEA_A_TBDIV) begin
                    tbdiv <= tbdiv_m[15:0];
                end
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // line input: three flops, change taken once second and third agree
    reg s1;
    reg s2;
    reg s3;
    reg line;
    reg line_d;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1     <= 1'b1;
            s2     <= 1'b1;
            s3     <= 1'b1;
            line   <= 1'b1;
            line_d <= 1'b1;
        end else begin
            s1     <= line_i;
            s2     <= s1;
            s3     <= s2;
            line_d <= line;
            if (s2 == s3) begin
                line <= s3 ^ inv;
            end
        end
    end
    wire rise = line && !line_d;
    wire fall = !line && line_d;
    wire edge_ev = rise || fall;

    // strap caught after reset release
    reg strap_done;
    reg prbs_long;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            strap_done <= 1'b0;
            prbs_long  <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            prbs_long  <= prbs_long_strap_i;
        end
    end

    // time base, counting clock and distortion counter
    reg  [15:0] tb_cnt;
    reg         dc_div;
    reg  [6:0]  phase;
    reg  [1:0]  adj;
    reg         in_char;
    reg  [3:0]  elem;
    wire        tick200 = (tb_cnt == tbdiv);
    wire        dc_tick = tick200 && dc_div;
    wire        run = sync || in_char;
    wire [6:0]  step = (adj == ADJ_HOLD) ? 7'h00 : (adj == ADJ_FAST) ? 7'h02 : 7'h01;
    wire [6:0]  psum = phase + step;
    wire        wrap = psum >= `TDEA_DC_PER_BIT;
    wire [6:0]  next_phase = wrap ? psum - `TDEA_DC_PER_BIT : psum;
    wire        bt = dc_tick && run && wrap;
    wire        mid = dc_tick && run && (phase == `TDEA_DIST_MAX) && (adj != ADJ_HOLD);
    wire        late = phase < `TDEA_DIST_MAX;
    wire [6:0]  dfull = late ? phase : `TDEA_DC_PER_BIT - phase;
    wire [5:0]  dval = dfull[5:0];
    wire        start_ev = !sync && !in_char && fall;
    wire [3:0]  stop_idx = {2'h0, lvl} + `TDEA_STOP_BASE;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tb_cnt     <= 16'h0000;
            dc_div     <= 1'b0;
            phase      <= 7'h00;
            adj        <= ADJ_NONE;
            in_char    <= 1'b0;
            elem       <= 4'h0;
            bit_sync_o <= 1'b0;
        end else if (start_ev) begin
            // character start realigns the counter to the start transition
            tb_cnt  <= 16'h0000;
            dc_div  <= 1'b0;
            phase   <= 7'h00;
            adj     <= ADJ_NONE;
            in_char <= 1'b1;
            elem    <= 4'h0;
        end else begin
            tb_cnt     <= tick200 ? 16'h0000 : tb_cnt + 16'h0001;
            bit_sync_o <= late;
            if (tick200) begin
                dc_div <= !dc_div;
            end
            if (dc_tick && run) begin
                phase <= next_phase;
                adj   <= ADJ_NONE;
                if (wrap) begin
                    elem <= elem + 4'h1;
                end
            end
            // synchronous input: drop or add a count to follow the line
            if (sync && edge_ev && dval != 6'h00) begin
                adj <= late ? ADJ_HOLD : ADJ_FAST;
            end
            if (in_char && elem == stop_idx && mid) begin
                in_char <= 1'b0;
            end
        end
    end

    // transfer strobe and distortion display
    wire [3:0] bidx = late ? elem : elem + 4'h1;
    wire       sel_ok = (tsel == 4'h0) || (!sync && bidx == tsel);
    reg        mode_ok;
    always @* begin
        case (mode)
            `TDEA_M_BIAS: mode_ok = rise;
            `TDEA_M_END:  mode_ok = fall && !sync;
            default:      mode_ok = edge_ev;
        endcase
    end
    wire latch_strobe = mode_ok && sel_ok && (sync || in_char);

    reg  [5:0]        latched;
    reg  [5:0]        peak;
    reg  signed [9:0] acc;
    reg  [30:0]       auto_cnt;
    wire              auto_tick = auto_en && (auto_cnt == AUTO_LAST);
    wire              dclr = cmd_dclr || auto_tick;
    wire signed [9:0] sv = late ? {4'h0, dval} : -{4'h0, dval};
    wire [9:0]        mag = acc[9] ? -acc : acc;
    wire              avg_early = acc[9];
    wire              avg_mode = (mode == `TDEA_M_BIAS) || (mode == `TDEA_M_END);
    wire              avg_nz = (acc != 10'sh000);

    assign marking_o = avg_mode && avg_nz
                    && ((mode == `TDEA_M_BIAS) ? avg_early : !avg_early);
    assign spacing_o = avg_mode && avg_nz
                    && ((mode == `TDEA_M_BIAS) ? !avg_early : avg_early);

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latched  <= 6'h00;
            peak     <= 6'h00;
            acc      <= 10'sh000;
            auto_cnt <= 31'h0000_0000;
        end else begin
            auto_cnt <= (auto_tick || !auto_en) ? 31'h0000_0000 : auto_cnt + 31'h0000_0001;
            if (latch_strobe) begin
                latched <= dval;
            end
            if (dclr) begin
                peak <= 6'h00;
                acc  <= 10'sh000;
            end else if (latch_strobe) begin
                if (mode == `TDEA_M_PEAK && dval > peak) begin
                    peak <= dval;
                end
                if (avg_mode) begin
                    // running average, weight one eighth per transition
                    acc <= acc + sv - (acc >>> 3);
                end
            end
        end
    end

    // parity, reversal and pseudo-random checking
    reg        par;
    reg        alt_exp;
    reg  [3:0] align_cnt;
    wire       aligning = (align_cnt != 4'h0);
    wire       prbs_exp;
    wire       par_mode = (mode == `TDEA_M_PARITY) && !sync && (lvl == `TDEA_LVL_8);
    wire       pe = par_mode && in_char && mid && (elem == stop_idx) && par;
    wire       pat_mode = sync && ((mode == `TDEA_M_ALT) || (mode == `TDEA_M_PRBS));
    wire       exp_bit = (mode == `TDEA_M_ALT) ? alt_exp : prbs_exp;
    wire       be = pat_mode && mid && !aligning && (line != exp_bit);

    tdea_prbs u_check (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .step_i     (pat_mode && mid),
        .seed_en_i  (aligning),
        .seed_bit_i (line),
        .long_i     (prbs_long),
        .bit_o      (prbs_exp)
    );

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            par          <= 1'b0;
            alt_exp      <= 1'b0;
            align_cnt    <= 4'h0;
            parity_err_o <= 1'b0;
            err_pulse_o  <= 1'b0;
        end else begin
            err_pulse_o <= be;
            if (in_char && mid) begin
                if (elem == 4'h0) begin
                    par <= 1'b0;
                end else if (elem < stop_idx) begin
                    par <= par ^ line;
                end
            end
            if (pat_mode && mid) begin
                alt_exp <= aligning ? !line : !alt_exp;
            end
            if (cmd_align) begin
                align_cnt <= `TDEA_ALIGN_BITS;
            end else if (aligning && pat_mode && mid) begin
                align_cnt <= align_cnt - 4'h1;
            end
            // a new error in the clearing cycle still lights the lamp
            if (pe && par_en) begin
                parity_err_o <= 1'b1;
            end else if (cmd_pclr) begin
                parity_err_o <= 1'b0;
            end
        end
    end

    // error counting over an interval
    reg  [5:0]  err_cnt;
    reg  [19:0] bits;
    reg  [30:0] comp_cnt;
    wire [19:0] limit = ival_limit(ival);
    wire        counting = !count_comp_o && !aligning;
    wire        restart = cmd_restart || (count_comp_o && comp_cnt == AUTO_LAST);

    assign overflow_o = (err_cnt == `TDEA_ERR_MAX);

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_cnt      <= 6'h00;
            bits         <= 20'h00000;
            comp_cnt     <= 31'h0000_0000;
            count_comp_o <= 1'b0;
        end else if (restart) begin
            err_cnt      <= 6'h00;
            bits         <= 20'h00000;
            comp_cnt     <= 31'h0000_0000;
            count_comp_o <= 1'b0;
        end else begin
            if ((pe || be) && counting && !overflow_o) begin
                err_cnt <= err_cnt + 6'h01;
            end
            if (count_comp_o) begin
                comp_cnt <= comp_cnt + 31'h0000_0001;
            end else if (bt && counting && ival != 3'h0) begin
                bits <= bits + 20'h00001;
                if (bits + 20'h00001 == limit) begin
                    count_comp_o <= 1'b1;
                end
            end
        end
    end

    // pattern generator, stepped at bit rate
    wire gen_bit;
    tdea_prbs u_gen (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .step_i     (bt),
        .seed_en_i  (1'b0),
        .seed_bit_i (1'b0),
        .long_i     (prbs_long),
        .bit_o      (gen_bit)
    );
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pattern_o <= 1'b1;
        end else if (bt) begin
            pattern_o <= (mode == `TDEA_M_ALT) ? !pattern_o : gen_bit;
        end
    end

    // read side
    wire [5:0] disp = (mode == `TDEA_M_PEAK) ? peak : avg_mode ? mag[8:3] : err_cnt;
    reg  [31:0] rd_mux;
    reg         rd_ok;
    always @* begin
        rd_ok = 1'b1;
        case (s_axi_araddr_i)
            `TDEA_A_CTRL:   rd_mux = ctrl;
            `TDEA_A_CMD:    rd_mux = 32'h0000_0000;
            `TDEA_A_STATUS: rd_mux = {17'h00000, line, aligning, count_comp_o, overflow_o,
                                      parity_err_o, spacing_o, marking_o, 2'h0, disp};
            `TDEA_A_ERRCNT: rd_mux = {26'h0000000, err_cnt};
            `TDEA_A_LATCH:  rd_mux = {26'h0000000, latched};
            `TDEA_A_TBDIV:  rd_mux = {16'h0000, tbdiv};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok  = 1'b0;
            end
        endcase
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= `TDEA_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_mux;
            s_axi_rresp_o  <= rd_ok ? `TDEA_RESP_OKAY : `TDEA_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verification/tdea_assertions.sv ***
// bus handshake and indicator assertions for the analyzer top
`timescale 1ns/10ps
`default_nettype none
module tdea_checker (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        s_axi_awready_o,
    input wire logic        s_axi_wready_o,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        err_pulse_o,
    input wire logic        bit_sync_o,
    input wire logic        parity_err_o,
    input wire logic        overflow_o,
    input wire logic        count_comp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data moved");
    write_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken while response pending");
    read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while data pending");
    err_pulse_a: assert property (err_pulse_o |=> !err_pulse_o)
        else $error("error pulse longer than a cycle");
    parity_lamp_a: assert property (parity_err_o |=> parity_err_o || s_axi_bvalid_o)
        else $error("parity lamp dropped without clear");
    overflow_hold_a: assert property (overflow_o && !count_comp_o
        |=> overflow_o || s_axi_bvalid_o) else $error("overflow dropped without restart");
    bit_half_a: assert property ($rose(bit_sync_o) |-> bit_sync_o [*8])
        else $error("bit timing half too short");
endmodule
bind tdea_top tdea_checker chk (.*);
`default_nettype wire

// *** verification/tdea_line_src.sv ***
// start-stop character source standing in for the equipment under test
`timescale 1ns/10ps
`default_nettype none
module tdea_line_src #(parameter int BIT = 200) (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] data_i,
    output wire logic       line_o,
    output var  logic       busy_o
);
    logic [9:0] sh = 10'h3FF;
    int         t  = 0;
    initial busy_o = 1'b0;
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            sh     <= {1'b1, data_i, 1'b0};
            t      <= 0;
            busy_o <= 1'b1;
        end else if (busy_o) begin
            t      <= t + 1;
            busy_o <= (t < 11 * BIT - 1);
        end
    end
    // idle and stop are mark, one spare stop bit before release
    assign line_o = (busy_o && t < 10 * BIT) ? sh[t / BIT] : 1'b1;
endmodule
`default_nettype wire

// *** verification/tdea_top_bench.sv ***
// self-checking bench for the analyzer top
`timescale 1ns/10ps
`default_nettype none
`include "tdea_consts.vh"
module tdea_top_bench;
    localparam int BIT = 200; // divider 0: one clock per 200x tick
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d, q; logic [1:0] r;} tdea_row_t;
    logic clk_i = 0, nrst_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, prbs_long_strap_i = 1, loop_back = 0;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, src_data = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic pattern_o, err_pulse_o, bit_sync_o, marking_o, spacing_o, parity_err_o, overflow_o;
    logic count_comp_o, src_go = 0, src_busy, src_line;
    wire logic line_i = loop_back ? pattern_o : src_line;
    int n_fail = 0, total_checks = 0, n_pulse = 0;
    tdea_row_t rows [8] = '{
        '{1'b0, `TDEA_A_CTRL, 0, `TDEA_CTRL_RST, `TDEA_RESP_OKAY},
        '{1'b0, `TDEA_A_TBDIV, 0, {16'h0, `TDEA_TBDIV_RST}, `TDEA_RESP_OKAY},
        '{1'b1, `TDEA_A_TBDIV, 0, 0, `TDEA_RESP_OKAY},
        '{1'b0, `TDEA_A_TBDIV, 0, 0, `TDEA_RESP_OKAY},
        '{1'b0, `TDEA_A_CMD, 0, 0, `TDEA_RESP_OKAY},
        '{1'b0, 8'h18, 0, 0, `TDEA_RESP_SLVERR},
        '{1'b1, 8'h1C, 32'h5, 0, `TDEA_RESP_SLVERR},
        '{1'b0, `TDEA_A_ERRCNT, 0, 0, `TDEA_RESP_OKAY}};
    tdea_top #(.AUTO_CLR_CYCLES(200)) uut (.*);
    tdea_line_src #(.BIT(BIT)) src (.clk_i(clk_i), .go_i(src_go), .data_i(src_data),
        .line_o(src_line), .busy_o(src_busy));
    initial forever #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (err_pulse_o === 1'b1) n_pulse <= n_pulse + 1;
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        logic ta, tw, tr, dn;
        int   k;
        dn = 0;
        @(posedge clk_i);
        s_axi_awaddr_i <= a; s_axi_araddr_i <= a; s_axi_wdata_i <= d;
        s_axi_awvalid_i <= w; s_axi_wvalid_i <= w; s_axi_bready_i <= w;
        s_axi_arvalid_i <= !w; s_axi_rready_i <= !w;
        for (k = 0; k < 100 && !dn; k++) begin
            @(negedge clk_i);
            ta = s_axi_awvalid_i & s_axi_awready_o;
            tw = s_axi_wvalid_i & s_axi_wready_o;
            tr = s_axi_arvalid_i & s_axi_arready_o;
            dn = w ? s_axi_bvalid_o : s_axi_rvalid_o;
            q  = w ? 32'h0 : s_axi_rdata_o;
            r  = w ? s_axi_bresp_o : s_axi_rresp_o;
            @(posedge clk_i);
            if (ta) s_axi_awvalid_i <= 0;
            if (tw) s_axi_wvalid_i <= 0;
            if (tr) s_axi_arvalid_i <= 0;
            if (dn) begin
                s_axi_bready_i <= 0;
                s_axi_rready_i <= 0;
            end
        end
        if (!dn) begin
            chk(0, 1, "bus timeout");
            report_and_stop;
        end
    endtask
    // w selects: 0 source busy, 1 overflow, 2 count complete
    task automatic wait_for(input int w, input logic v, input int lim, output int k);
        logic [2:0] s;
        for (k = 0; k < lim; k++) begin
            @(negedge clk_i);
            s = {count_comp_o, overflow_o, src_busy};
            @(posedge clk_i);
            if (s[w] === v) return;
        end
        chk(0, 1, "wait timeout");
        report_and_stop;
    endtask
    initial begin
        logic [31:0] q;
        logic [1:0]  r;
        int          k, p;
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d, q, r);
            chk(q, rows[i].q, "register data");
            chk({30'h0, r}, {30'h0, rows[i].r}, "response code");
        end
        bus(1, `TDEA_A_CTRL, 32'h0833, q, r); // parity mode, 8 level, lamp on
        foreach (rows[i]) if (i < 3) begin
            src_data <= (i == 1) ? 8'h01 : 8'h03; // even, odd, then even data
            src_go <= 1'b1;
            wait_for(0, 1, 10, k);
            src_go <= 1'b0;
            wait_for(0, 0, 12 * BIT, k);
            chk(parity_err_o, i > 0, "parity lamp");
        end
        bus(0, `TDEA_A_ERRCNT, 0, q, r);
        chk(q, 1, "parity count");
        bus(1, `TDEA_A_CMD, 32'h2, q, r);
        chk(parity_err_o, 0, "lamp clear");
        loop_back <= 1'b1; // generated pattern fed back, sync input
        foreach (rows[i]) if (i < 2) begin
            bus(1, `TDEA_A_CTRL, i ? 32'hD : 32'hC, q, r);
            bus(1, `TDEA_A_CMD, 32'hC, q, r);
            repeat (40 * BIT) @(posedge clk_i);
            bus(0, `TDEA_A_ERRCNT, 0, q, r);
            chk(q, 0, "clean pattern count");
        end
        bus(1, `TDEA_A_CTRL, 32'h800D, q, r); // inverted: every bit wrong
        wait_for(1, 1, 70 * BIT, k);
        p = n_pulse;
        repeat (10 * BIT) @(posedge clk_i);
        bus(0, `TDEA_A_ERRCNT, 0, q, r);
        chk(q, 32'h32, "count held at overflow");
        chk(n_pulse - p > 7, 1, "pulses past overflow");
        bus(1, `TDEA_A_CTRL, 32'h100D, q, r);
        bus(1, `TDEA_A_CMD, 32'h8, q, r);
        wait_for(2, 1, 103 * BIT, k);
        chk(k >= 99 * BIT, 1, "interval length");
        bus(0, `TDEA_A_ERRCNT, 0, q, r);
        chk(q, 0, "clean interval count");
        wait_for(2, 0, 300, k);
        chk(k > 150, 1, "auto restart delay");
        report_and_stop;
    end
endmodule
`default_nettype wire
